//--- hdl/adcc_top.sv
// Converter control and status register with start-trigger selection
//
// Overview of operation
// - Power bit 7 gates converter active state
// - Bit 6 selects single or burst conversions
// - Bit 5 set on conversion finish in single mode, burst finish in burst mode
// - Done flag never cleared by hardware
// - Writing 1 to bit 4 starts, mode 000
// - Bit 3 set on window hit while powered, software clears
// - Timer 0 overflow starts, modes 001/010
// - Timer 3 overflow starts, mode 011
// - External pin rise starts when mode 1xx
`timescale 1ns/10ps
`include "adcc_defs.svh"
module adcc_top
  import adcc_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Special function register port
  input wire adcc_sfr_req_type sfr_req,
  output logic [7:0] sfr_rdata_q,
  // Trigger sources
  input wire logic timer0_overflow,
  input wire logic timer3_overflow,
  input wire logic external_convert_start,
  // Converter core
  input wire adcc_core_evt_type core_evt,
  output logic converter_power_on,
  output logic burst_select,
  output logic conv_start_q,
  // Interrupt request flags
  output logic conversion_done_flag,
  output logic window_hit_flag
);
  adcc_ctl_type ctl_q;
  adcc_ctl_type ctl_d;
  adcc_ctl_type wr_val;
  adcc_state_type state_q;
  adcc_state_type state_d;
  logic [7:0] rdata_d;
  logic start_d;
  logic hit_sel;
  logic sw_busy_wr;
  logic trig;
  logic finish;
  logic ext_rise;

  // Merge a byte write or a single-bit write into the register image
  function automatic logic [7:0] apply_write(input logic [7:0] cur,
                                             input adcc_sfr_req_type r);
    logic [7:0] v;
    v = cur;
    if (r.byte_wr) begin
      v = r.wdata;
    end else if (r.bit_wr) begin
      v[r.bit_sel] = r.bit_val;
    end
    return v;
  endfunction

  // Pin crosses into the clock domain before edge detection
  adcc_sync u_ext_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .pin_in(external_convert_start),
    .level_q(),
    .rise_q(ext_rise)
  );

  // Register decode, trigger selection and sticky flags
  always_comb begin
    hit_sel = (sfr_req.addr == `ADCC_CTL_ADDR);
    wr_val = adcc_ctl_type'(apply_write(8'(ctl_q), sfr_req));
    sw_busy_wr = hit_sel && (sfr_req.byte_wr || sfr_req.bit_wr) &&
                 wr_val.busy;
    if (sfr_req.bit_wr && !sfr_req.byte_wr &&
        sfr_req.bit_sel != `ADCC_BIT_BUSY) begin
      sw_busy_wr = 1'b0; // Bit write elsewhere is no start
    end
    trig = 1'b0;
    if (ctl_q.mode[`ADCC_MODE_MSB]) begin
      trig = ext_rise;
    end else begin
      case (ctl_q.mode)
        `ADCC_MODE_SW: trig = sw_busy_wr;
        `ADCC_MODE_T0A, `ADCC_MODE_T0B: trig = timer0_overflow;
        `ADCC_MODE_T3: trig = timer3_overflow;
        default: trig = 1'b0;
      endcase
    end
    // Only an idle, powered converter accepts a start
    start_d = trig && ctl_q.power && (state_q == ADCC_IDLE);
    finish = (state_q == ADCC_CONVERTING) &&
             (ctl_q.burst ? core_evt.burst_done : core_evt.conv_done);
    state_d = state_q;
    if (start_d) begin
      state_d = ADCC_CONVERTING;
    end else if (finish || !ctl_q.power) begin
      state_d = ADCC_IDLE;
    end
    // Software owns power, burst, mode and may clear flags
    ctl_d = ctl_q;
    if (hit_sel && (sfr_req.byte_wr || sfr_req.bit_wr)) begin
      ctl_d.power = wr_val.power;
      ctl_d.burst = wr_val.burst;
      ctl_d.mode = wr_val.mode;
      ctl_d.done = wr_val.done;
      ctl_d.win = wr_val.win;
    end
    // Hardware sets win over a clear in the same cycle
    if (finish) begin
      ctl_d.done = 1'b1;
    end
    if (core_evt.window_hit && ctl_q.power) begin
      ctl_d.win = 1'b1;
    end
    ctl_d.busy = (state_d == ADCC_CONVERTING);
    rdata_d = 8'h00;
    if (hit_sel && sfr_req.rd) begin
      rdata_d = 8'(ctl_q);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctl_q <= adcc_ctl_type'(`ADCC_CTL_RESET);
      state_q <= ADCC_IDLE;
      sfr_rdata_q <= 8'h00;
      conv_start_q <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      state_q <= state_d;
      sfr_rdata_q <= rdata_d;
      conv_start_q <= start_d;
    end
  end

  // Register-fed outputs toward the core and interrupt logic
  assign converter_power_on = ctl_q.power;
  assign burst_select = ctl_q.burst;
  assign conversion_done_flag = ctl_q.done;
  assign window_hit_flag = ctl_q.win;

  AST_START_NEEDS_POWER: assert property (@(posedge ref_clk)
    disable iff (!nrst) conv_start_q |-> $past(ctl_q.power))
    else $error("start issued while converter was off");

  AST_START_MARKS_BUSY: assert property (@(posedge ref_clk)
    disable iff (!nrst) conv_start_q |-> ctl_q.busy && !$past(ctl_q.busy))
    else $error("start did not raise busy from idle");

  AST_SINGLE_DONE: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (ctl_q.busy && !ctl_q.burst && core_evt.conv_done && ctl_q.power &&
     !trig) |=> ctl_q.done && !ctl_q.busy)
    else $error("single conversion finish missed");

  AST_BURST_DONE: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (ctl_q.busy && ctl_q.burst && core_evt.burst_done) |=> ctl_q.done)
    else $error("burst finish missed");

  AST_DONE_STICKY: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (ctl_q.done && !(hit_sel && (sfr_req.byte_wr || sfr_req.bit_wr)))
    |=> ctl_q.done)
    else $error("done flag cleared without software");

  AST_WINDOW_SET: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (core_evt.window_hit && ctl_q.power) |=> ctl_q.win)
    else $error("window hit not flagged");

  AST_SW_START: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (sw_busy_wr && ctl_q.mode == `ADCC_MODE_SW && ctl_q.power &&
     !ctl_q.busy) |=> conv_start_q)
    else $error("software start ignored");

  AST_SW_GATED: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (ctl_q.mode != `ADCC_MODE_SW && !timer0_overflow && !timer3_overflow &&
     !ext_rise) |=> !conv_start_q)
    else $error("start without selected trigger");

  AST_TIMER0: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (timer0_overflow && ctl_q.power && !ctl_q.busy &&
     (ctl_q.mode == `ADCC_MODE_T0A || ctl_q.mode == `ADCC_MODE_T0B))
    |=> conv_start_q)
    else $error("timer 0 overflow ignored");

  AST_TIMER3: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (timer3_overflow && ctl_q.power && !ctl_q.busy &&
     ctl_q.mode == `ADCC_MODE_T3) |=> conv_start_q)
    else $error("timer 3 overflow ignored");

  AST_EXT_PIN: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (ext_rise && ctl_q.power && !ctl_q.busy &&
     ctl_q.mode[`ADCC_MODE_MSB]) |=> conv_start_q)
    else $error("external rise ignored");

  AST_OFF_GOES_IDLE: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    !ctl_q.power |=> !ctl_q.busy)
    else $error("busy held while converter off");

  AST_BURST_HOLDS: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (ctl_q.busy && ctl_q.burst && ctl_q.power && !core_evt.burst_done)
    |=> ctl_q.busy)
    else $error("burst ended without burst finish");

  AST_IDLE_NO_DONE: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (!ctl_q.busy && !ctl_q.done &&
     !(hit_sel && (sfr_req.byte_wr || sfr_req.bit_wr))) |=> !ctl_q.done)
    else $error("done flag set while idle");

  AST_WIN_STICKY: assert property (@(posedge ref_clk)
    disable iff (!nrst)
    (ctl_q.win && !(hit_sel && (sfr_req.byte_wr || sfr_req.bit_wr)))
    |=> ctl_q.win)
    else $error("window flag cleared without software");
endmodule

//--- hdl/adcc_defs.svh
// Constants for the converter control block
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH
`define ADCC_CTL_ADDR 8'he8
`define ADCC_CTL_RESET 8'h00
`define ADCC_BIT_POWER 3'h7
`define ADCC_BIT_BURST 3'h6
`define ADCC_BIT_DONE 3'h5
`define ADCC_BIT_BUSY 3'h4
`define ADCC_BIT_WIN 3'h3
`define ADCC_MODE_MSB 2
`define ADCC_MODE_LSB 0
`define ADCC_MODE_SW 3'h0
`define ADCC_MODE_T0A 3'h1
`define ADCC_MODE_T0B 3'h2
`define ADCC_MODE_T3 3'h3
`endif

//--- hdl/adcc_pkg.sv
// Types shared by the converter control block
package adcc_pkg;
  // Control and status register layout, bit 7 down to bit 0
  typedef struct packed {
    logic power;
    logic burst;
    logic done;
    logic busy;
    logic win;
    logic [2:0] mode;
  } adcc_ctl_type;

  // Events reported by the analog converter core
  typedef struct packed {
    logic conv_done;
    logic burst_done;
    logic window_hit;
  } adcc_core_evt_type;

  // Special function register access
  typedef struct packed {
    logic [7:0] addr;
    logic byte_wr;
    logic rd;
    logic [7:0] wdata;
    logic bit_wr;
    logic [2:0] bit_sel;
    logic bit_val;
  } adcc_sfr_req_type;

  typedef enum logic {ADCC_IDLE, ADCC_CONVERTING} adcc_state_type;
endpackage

//--- hdl/adcc_sync.sv
// Three-stage pin synchroniser with agreement filter and rise detect
`timescale 1ns/10ps
module adcc_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Asynchronous pin
  input wire logic pin_in,
  // Filtered level and rising edge pulse
  output logic level_q,
  output logic rise_q
);
  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic level_d;
  logic rise_d;

  // Stage 0 feeds only stage 1; level moves only when 1 and 2 agree
  always_comb begin
    stage_d = {stage_q[1:0], pin_in};
    level_d = level_q;
    if (stage_q[1] == stage_q[2]) begin
      level_d = stage_q[2];
    end
    rise_d = level_d & ~level_q;
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      stage_q <= 3'h0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
    end else begin
      stage_q <= stage_d;
      level_q <= level_d;
      rise_q <= rise_d;
    end
  end
endmodule

//--- verif/adcc_top_bench.sv
// Self-checking bench for the converter control register block
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  errors++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module adcc_top_bench;
  import adcc_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  adcc_sfr_req_type sfr_req = '0;
  adcc_core_evt_type core_evt = '0;
  logic t0 = 1'b0;
  logic t3 = 1'b0;
  logic pin = 1'b0;
  logic [7:0] sfr_rdata_q;
  logic pwr, burst, start, done_f, win_f;
  logic took = 1'b0;
  logic [7:0] expq[$];
  logic [7:0] exp_rd;
  logic [31:0] rng = 32'hc130;
  int errors = 0;
  int samples_checked = 0;
  int starts = 0;
  int exp_starts = 0;

  adcc_top dut_u (.ref_clk(ref_clk), .nrst(nrst), .sfr_req(sfr_req),
    .sfr_rdata_q(sfr_rdata_q), .timer0_overflow(t0), .timer3_overflow(t3),
    .external_convert_start(pin), .core_evt(core_evt),
    .converter_power_on(pwr), .burst_select(burst), .conv_start_q(start),
    .conversion_done_flag(done_f), .window_hit_flag(win_f));

  // Clock, 8 ns period
  always #4 ref_clk = ~ref_clk;

  // Start pulses counted as they leave the block
  // An unknown start counts too, so it cannot hide behind a match
  always @(posedge ref_clk) if (nrst && start !== 1'b0) starts++;

  // Read watcher: data is registered, so check at the next falling edge
  always @(posedge ref_clk) took <= sfr_req.rd;
  always @(negedge ref_clk) begin
    if (took && expq.size() > 0) begin
      // Pop once; the macro names its arguments twice
      exp_rd = expq.pop_front();
      `CHK(sfr_rdata_q, exp_rd)
    end
  end

  function automatic logic [7:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    sfr_req.addr = a;
    sfr_req.wdata = d;
    sfr_req.byte_wr = 1'b1;
    @(negedge ref_clk);
    sfr_req.byte_wr = 1'b0;
  endtask

  task automatic bw(input logic [2:0] s, input logic v);
    @(negedge ref_clk);
    sfr_req.addr = 8'he8;
    sfr_req.bit_sel = s;
    sfr_req.bit_val = v;
    sfr_req.bit_wr = 1'b1;
    @(negedge ref_clk);
    sfr_req.bit_wr = 1'b0;
  endtask

  // Expected value is queued on the same falling edge the strobe goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge ref_clk);
    sfr_req.addr = a;
    sfr_req.rd = 1'b1;
    expq.push_back(e);
    @(negedge ref_clk);
    sfr_req.rd = 1'b0;
  endtask

  // One-cycle pulse: 0 timer0, 1 timer3, 2 done, 3 burst done, 4 window
  task automatic pulse(input int w);
    @(negedge ref_clk);
    case (w)
      0: t0 = 1'b1;
      1: t3 = 1'b1;
      2: core_evt.conv_done = 1'b1;
      3: core_evt.burst_done = 1'b1;
      default: core_evt.window_hit = 1'b1;
    endcase
    @(negedge ref_clk);
    t0 = 1'b0;
    t3 = 1'b0;
    core_evt = '0;
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog cuts a hang short
  initial begin
    #200000;
    errors++;
    end_of_test();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'b1;
    rd(8'he8, 8'h00);
    wr(8'he8, 8'h90);
    rd(8'he8, 8'h80);
    `CHK(pwr, 1'b1)
    wr(8'he8, 8'h90);
    exp_starts++;
    rd(8'he8, 8'h90);
    pulse(2);
    rd(8'he8, 8'ha0);
    pulse(4);
    repeat (5) @(negedge ref_clk);
    rd(8'he8, 8'ha8);
    `CHK(win_f, 1'b1)
    bw(3'h5, 1'b0);
    bw(3'h3, 1'b0);
    rd(8'he8, 8'h80);
    $display("test software start done");
    // Leave software mode first: the old mode decides a busy write
    wr(8'he8, 8'h81);
    // Every timer and pin mode: busy write, wrong source, then right source
    for (int m = 1; m < 8; m++) begin
      wr(8'he8, 8'h90 | m[7:0]);
      pulse(m == 3 ? 0 : 1);
      if (m > 3) pulse(0);
      rd(8'he8, 8'h80 | m[7:0]);
      if (m < 4) begin
        pulse(m == 3 ? 1 : 0);
        pulse(m == 3 ? 1 : 0);
      end else begin
        @(negedge ref_clk);
        pin = 1'b1;
        repeat (8) @(negedge ref_clk);
        pin = 1'b0;
      end
      exp_starts++;
      rd(8'he8, 8'h90 | m[7:0]);
      `CHK(starts, exp_starts)
      pulse(2);
      rd(8'he8, 8'ha0 | m[7:0]);
      bw(3'h5, 1'b0);
    end
    $display("test trigger modes done");
    wr(8'he8, 8'hc1);
    `CHK(burst, 1'b1)
    pulse(0);
    exp_starts++;
    pulse(2);
    rd(8'he8, 8'hd1);
    pulse(3);
    rd(8'he8, 8'he1);
    `CHK(done_f, 1'b1)
    $display("test burst done");
    // Power off in mid-conversion must drop busy
    pulse(0);
    exp_starts++;
    wr(8'he8, 8'h01);
    pulse(0);
    pulse(4);
    rd(8'he8, 8'h01);
    `CHK(starts, exp_starts)
    repeat (4) wr(8'he9, xs());
    rd(8'he9, 8'h00);
    rd(8'he8, 8'h01);
    $display("test power off and unmapped done");
    wr(8'he8, 8'h81);
    @(negedge ref_clk);
    nrst = 1'b0;
    @(negedge ref_clk);
    nrst = 1'b1;
    rd(8'he8, 8'h00);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule
